/* File: dad_defines.svh */
`ifndef DAD_DEFINES_SVH
`define DAD_DEFINES_SVH
`define DAD_ADDR_MODE_BIT 7
`define DAD_DIR_MSB 6
`define DAD_SHORT_MSB 7
`define DAD_AUX_MSB 10
`define DAD_AUX_LSB 8
`define DAD_SHIFT_MSB 11
`define DAD_SHIFT_LSB 8
`define DAD_PAGE_MSB 8
`define DAD_MIMM_MSB 12
`define DAD_SEL2_MSB 1
`define DAD_HI_SUB_SHIFT_MPLCND 8'h46
`define DAD_HI_XOR_MEMORY 8'h4C
`define DAD_HI_CLR_LOAD_HIGH 8'h40
`define DAD_HI_CLR_LOAD_ROUND 8'h7B
`define DAD_HI_CLR_LOAD_LOW 8'h41
`define DAD_HI_AUX_ADD_SHORT 8'h7E
`define DAD_HI_AUX_MODIFY 8'h55
`define DAD_HI_PAGE_LOAD 8'h52
`define DAD_HI_PROD_HIGH_LOAD 8'h53
`define DAD_HI_PROD_HIGH_STORE 8'h7D
`define DAD_HI_PROD_LOW_STORE 8'h7C
`define DAD_HI_MPLCND_LOAD 8'h3C
`define DAD_HI_MPLCND_ACC 8'h3D
`define DAD_HI_MPLCND_SUB 8'h5B
`define DAD_HI_MPLCND_ACC_MOVE 8'h3F
`define DAD_HI_MPLCND_STORE_PROD 8'h3E
`define DAD_HI_MULT_ACC 8'h5D
`define DAD_HI_MULT_ACC_MOVE 8'h5C
`define DAD_HI_MULTIPLY 8'h38
`define DAD_HI_MULTIPLY_SUB 8'h3B
`define DAD_HI_MULTIPLY_UNSIGNED 8'hCF
`define DAD_HI_MULTIPLY_ACC 8'h3A
`define DAD_HI_SQUARE_ACC 8'h39
`define DAD_HI_SQUARE_SUB 8'h5A
`define DAD_TOP5_AUX_LOAD 5'h06
`define DAD_TOP5_AUX_STORE 5'h0E
`define DAD_TOP5_AUX_SHORT 5'h18
`define DAD_TOP5_AUX_LONG 5'h1A
`define DAD_TOP7_PAGE_IMM 7'h64
`define DAD_TOP3_MULT_IMM 3'h5
`define DAD_TOP4_XOR_LONG 4'hD
`define DAD_LO_XOR_LONG 8'h06
`define DAD_LO_AUX_LONG 8'h00
`define DAD_LO5_AUX_POINTER 5'h11
`define DAD_TOP14_COMPARE 14'h3394
`define DAD_TOP14_SHIFT_MODE 14'h3382
`define DAD_W_CLEAR_ACC 16'hCA00
`define DAD_W_ADD_PRODUCT 16'hCE15
`define DAD_W_ACC_FROM_PRODUCT 16'hCE14
`define DAD_W_SUB_PRODUCT 16'hCE16
`endif

/* File: dad_pkg.sv */
package dad_pkg;
    typedef enum logic [5:0] {
        op_none,
        op_sub_shift_by_multiplicand,
        op_xor_memory,
        op_xor_long_immediate,
        op_clear_accumulator,
        op_clear_load_low_unsigned,
        op_clear_load_high_half,
        op_clear_load_high_round,
        op_aux_add_short_imm,
        op_aux_compare,
        op_aux_load,
        op_aux_store,
        op_aux_load_long_imm,
        op_aux_load_short_imm,
        op_aux_modify,
        op_aux_pointer_load,
        op_page_pointer_load,
        op_page_pointer_load_imm,
        op_add_product,
        op_accumulator_from_product,
        op_subtract_product,
        op_product_high_load,
        op_product_high_store,
        op_product_low_store,
        op_multiplicand_load,
        op_multiplicand_load_accumulate,
        op_multiplicand_load_subtract,
        op_multiplicand_load_acc_move,
        op_multiplicand_load_store_product,
        op_mult_accumulate,
        op_mult_accumulate_move,
        op_multiply,
        op_multiply_subtract_previous,
        op_multiply_unsigned,
        op_multiply_accumulate_previous,
        op_multiply_immediate,
        op_square_accumulate,
        op_square_subtract,
        op_product_shift_mode_set
    } dad_op_t;

    typedef enum logic {
        st_idle,
        st_wait_second
    } dad_state_t;
endpackage

/* File: dad_field_extract.sv */
`timescale 1ns/1ps
`include "dad_defines.svh"

// pulls every operand field out of a word; which ones matter depends on the op
module dad_field_extract (
    input  wire logic [15:0] word,
    output logic             addr_mode,
    output logic [6:0]       direct_addr,
    output logic [7:0]       short_imm,
    output logic [3:0]       left_shift,
    output logic [2:0]       aux_sel,
    output logic [1:0]       sel2,
    output logic [8:0]       page_imm,
    output logic [12:0]      mult_imm
);
    assign addr_mode   = word[`DAD_ADDR_MODE_BIT];
    assign direct_addr = word[`DAD_DIR_MSB:0];
    assign short_imm   = word[`DAD_SHORT_MSB:0];
    assign left_shift  = word[`DAD_SHIFT_MSB:`DAD_SHIFT_LSB];
    assign aux_sel     = word[`DAD_AUX_MSB:`DAD_AUX_LSB];
    assign sel2        = word[`DAD_SEL2_MSB:0];
    assign page_imm    = word[`DAD_PAGE_MSB:0];
    assign mult_imm    = word[`DAD_MIMM_MSB:0];
endmodule

/* File: dad_decoder.sv */
`timescale 1ns/1ps
`include "dad_defines.svh"

module dad_decoder (
    input  wire logic           clk,
    input  wire logic           srst,
    input  wire logic           instr_valid,
    input  wire logic [15:0]    instr_word,
    output dad_pkg::dad_op_t    op,
    output logic                decode_done,
    output logic                two_word,
    output logic                second_word_needed,
    output logic                not_in_group,
    output logic                addr_mode,
    output logic [6:0]          direct_addr,
    output logic [7:0]          short_imm,
    output logic [15:0]         long_operand,
    output logic [3:0]          left_shift,
    output logic [2:0]          aux_sel,
    output logic [1:0]          compare_mode_field,
    output logic [1:0]          product_shift_code,
    output logic [8:0]          page_pointer_field,
    output logic [12:0]         mult_imm
);
    dad_pkg::dad_state_t state;

    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [4:0]  top5;
    logic        f_addr_mode;
    logic [6:0]  f_direct;
    logic [7:0]  f_short;
    logic [3:0]  f_shift;
    logic [2:0]  f_aux;
    logic [1:0]  f_sel2;
    logic [8:0]  f_page;
    logic [12:0] f_mimm;

    assign hi   = instr_word[15:8];
    assign lo   = instr_word[7:0];
    assign top5 = instr_word[15:11];

    dad_field_extract u_fields (
        .word        (instr_word),
        .addr_mode   (f_addr_mode),
        .direct_addr (f_direct),
        .short_imm   (f_short),
        .left_shift  (f_shift),
        .aux_sel     (f_aux),
        .sel2        (f_sel2),
        .page_imm    (f_page),
        .mult_imm    (f_mimm)
    );

    // accumulator memory-reference tail
    logic hit_sub_shift;
    logic hit_xor_mem;
    logic hit_xor_long;
    logic hit_clr_acc;
    logic hit_clr_low;
    logic hit_clr_high;
    logic hit_clr_round;
    // auxiliary register and page pointer group
    logic hit_aux_add;
    logic hit_aux_cmp;
    logic hit_aux_load;
    logic hit_aux_store;
    logic hit_aux_long;
    logic hit_aux_short;
    logic hit_aux_ptr;
    logic hit_aux_mod;
    logic hit_page_load;
    logic hit_page_imm;
    // multiplicand, product and multiply group
    logic hit_add_prod;
    logic hit_acc_prod;
    logic hit_sub_prod;
    logic hit_ph_load;
    logic hit_ph_store;
    logic hit_pl_store;
    logic hit_t_load;
    logic hit_t_acc;
    logic hit_t_sub;
    logic hit_t_move;
    logic hit_t_store;
    logic hit_mac;
    logic hit_mac_move;
    logic hit_mul;
    logic hit_mul_sub;
    logic hit_mul_uns;
    logic hit_mul_acc;
    logic hit_mul_imm;
    logic hit_sq_acc;
    logic hit_sq_sub;
    logic hit_shift_mode;

    assign hit_sub_shift  = hi == `DAD_HI_SUB_SHIFT_MPLCND;
    assign hit_xor_mem    = hi == `DAD_HI_XOR_MEMORY;
    assign hit_xor_long   = instr_word[15:12] == `DAD_TOP4_XOR_LONG
                            && lo == `DAD_LO_XOR_LONG;
    assign hit_clr_acc    = instr_word == `DAD_W_CLEAR_ACC;
    assign hit_clr_low    = hi == `DAD_HI_CLR_LOAD_LOW;
    assign hit_clr_high   = hi == `DAD_HI_CLR_LOAD_HIGH;
    assign hit_clr_round  = hi == `DAD_HI_CLR_LOAD_ROUND;
    assign hit_aux_add    = hi == `DAD_HI_AUX_ADD_SHORT;
    assign hit_aux_cmp    = instr_word[15:2] == `DAD_TOP14_COMPARE;
    assign hit_aux_load   = top5 == `DAD_TOP5_AUX_LOAD;
    assign hit_aux_store  = top5 == `DAD_TOP5_AUX_STORE;
    assign hit_aux_long   = top5 == `DAD_TOP5_AUX_LONG
                            && lo == `DAD_LO_AUX_LONG;
    assign hit_aux_short  = top5 == `DAD_TOP5_AUX_SHORT;
    assign hit_aux_ptr    = hi == `DAD_HI_AUX_MODIFY
                            && lo[7:3] == `DAD_LO5_AUX_POINTER;
    assign hit_aux_mod    = hi == `DAD_HI_AUX_MODIFY && !hit_aux_ptr;
    assign hit_page_load  = hi == `DAD_HI_PAGE_LOAD;
    assign hit_page_imm   = instr_word[15:9] == `DAD_TOP7_PAGE_IMM;
    assign hit_add_prod   = instr_word == `DAD_W_ADD_PRODUCT;
    assign hit_acc_prod   = instr_word == `DAD_W_ACC_FROM_PRODUCT;
    assign hit_sub_prod   = instr_word == `DAD_W_SUB_PRODUCT;
    assign hit_ph_load    = hi == `DAD_HI_PROD_HIGH_LOAD;
    assign hit_ph_store   = hi == `DAD_HI_PROD_HIGH_STORE;
    assign hit_pl_store   = hi == `DAD_HI_PROD_LOW_STORE;
    assign hit_t_load     = hi == `DAD_HI_MPLCND_LOAD;
    assign hit_t_acc      = hi == `DAD_HI_MPLCND_ACC;
    assign hit_t_sub      = hi == `DAD_HI_MPLCND_SUB;
    assign hit_t_move     = hi == `DAD_HI_MPLCND_ACC_MOVE;
    assign hit_t_store    = hi == `DAD_HI_MPLCND_STORE_PROD;
    assign hit_mac        = hi == `DAD_HI_MULT_ACC;
    assign hit_mac_move   = hi == `DAD_HI_MULT_ACC_MOVE;
    assign hit_mul        = hi == `DAD_HI_MULTIPLY;
    assign hit_mul_sub    = hi == `DAD_HI_MULTIPLY_SUB;
    assign hit_mul_uns    = hi == `DAD_HI_MULTIPLY_UNSIGNED;
    assign hit_mul_acc    = hi == `DAD_HI_MULTIPLY_ACC;
    assign hit_mul_imm    = instr_word[15:13] == `DAD_TOP3_MULT_IMM;
    assign hit_sq_acc     = hi == `DAD_HI_SQUARE_ACC;
    assign hit_sq_sub     = hi == `DAD_HI_SQUARE_SUB;
    assign hit_shift_mode = instr_word[15:2] == `DAD_TOP14_SHIFT_MODE;

    // encodings are disjoint, so the order of this chain is not a priority
    dad_pkg::dad_op_t next_op;
    assign next_op =
        hit_sub_shift  ? dad_pkg::op_sub_shift_by_multiplicand :
        hit_xor_mem    ? dad_pkg::op_xor_memory :
        hit_xor_long   ? dad_pkg::op_xor_long_immediate :
        hit_clr_acc    ? dad_pkg::op_clear_accumulator :
        hit_clr_low    ? dad_pkg::op_clear_load_low_unsigned :
        hit_clr_high   ? dad_pkg::op_clear_load_high_half :
        hit_clr_round  ? dad_pkg::op_clear_load_high_round :
        hit_aux_add    ? dad_pkg::op_aux_add_short_imm :
        hit_aux_cmp    ? dad_pkg::op_aux_compare :
        hit_aux_load   ? dad_pkg::op_aux_load :
        hit_aux_store  ? dad_pkg::op_aux_store :
        hit_aux_long   ? dad_pkg::op_aux_load_long_imm :
        hit_aux_short  ? dad_pkg::op_aux_load_short_imm :
        hit_aux_ptr    ? dad_pkg::op_aux_pointer_load :
        hit_aux_mod    ? dad_pkg::op_aux_modify :
        hit_page_load  ? dad_pkg::op_page_pointer_load :
        hit_page_imm   ? dad_pkg::op_page_pointer_load_imm :
        hit_add_prod   ? dad_pkg::op_add_product :
        hit_acc_prod   ? dad_pkg::op_accumulator_from_product :
        hit_sub_prod   ? dad_pkg::op_subtract_product :
        hit_ph_load    ? dad_pkg::op_product_high_load :
        hit_ph_store   ? dad_pkg::op_product_high_store :
        hit_pl_store   ? dad_pkg::op_product_low_store :
        hit_t_load     ? dad_pkg::op_multiplicand_load :
        hit_t_acc      ? dad_pkg::op_multiplicand_load_accumulate :
        hit_t_sub      ? dad_pkg::op_multiplicand_load_subtract :
        hit_t_move     ? dad_pkg::op_multiplicand_load_acc_move :
        hit_t_store    ? dad_pkg::op_multiplicand_load_store_product :
        hit_mac        ? dad_pkg::op_mult_accumulate :
        hit_mac_move   ? dad_pkg::op_mult_accumulate_move :
        hit_mul        ? dad_pkg::op_multiply :
        hit_mul_sub    ? dad_pkg::op_multiply_subtract_previous :
        hit_mul_uns    ? dad_pkg::op_multiply_unsigned :
        hit_mul_acc    ? dad_pkg::op_multiply_accumulate_previous :
        hit_mul_imm    ? dad_pkg::op_multiply_immediate :
        hit_sq_acc     ? dad_pkg::op_square_accumulate :
        hit_sq_sub     ? dad_pkg::op_square_subtract :
        hit_shift_mode ? dad_pkg::op_product_shift_mode_set :
                         dad_pkg::op_none;

    // words that carry a second operand word
    logic next_two_word;
    assign next_two_word = hit_xor_long | hit_aux_long | hit_mac | hit_mac_move;

    // nothing in this group claimed the word
    logic next_foreign;
    assign next_foreign = next_op == dad_pkg::op_none;

    logic take_first;
    logic take_second;
    assign take_first  = instr_valid && state == dad_pkg::st_idle;
    assign take_second = instr_valid && state == dad_pkg::st_wait_second;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state              <= dad_pkg::st_idle;
            second_word_needed <= 1'b0;
            decode_done        <= 1'b0;
        end
        else
        begin
            case (state)
                dad_pkg::st_idle:
                begin
                    // hold request until operand word arrives
                    if (take_first && next_two_word)
                    begin
                        state              <= dad_pkg::st_wait_second;
                        second_word_needed <= 1'b1;
                    end
                    decode_done <= take_first && !next_two_word;
                end
                dad_pkg::st_wait_second:
                begin
                    if (take_second)
                    begin
                        state              <= dad_pkg::st_idle;
                        second_word_needed <= 1'b0;
                    end
                    decode_done <= take_second;
                end
                default:
                begin
                    state              <= dad_pkg::st_idle;
                    second_word_needed <= 1'b0;
                    decode_done        <= 1'b0;
                end
            endcase
        end
    end

    // decoded fields stay put until the next first word is taken
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            op                 <= dad_pkg::op_none;
            two_word           <= 1'b0;
            not_in_group       <= 1'b0;
            addr_mode          <= 1'b0;
            direct_addr        <= 7'h00;
            short_imm          <= 8'h00;
            left_shift         <= 4'h0;
            aux_sel            <= 3'h0;
            compare_mode_field <= 2'h0;
            product_shift_code <= 2'h0;
            page_pointer_field <= 9'h000;
            mult_imm           <= 13'h0000;
        end
        else if (take_first)
        begin
            op                 <= next_op;
            two_word           <= next_two_word;
            not_in_group       <= next_foreign;
            addr_mode          <= f_addr_mode;
            direct_addr        <= f_direct;
            short_imm          <= f_short;
            left_shift         <= f_shift;
            aux_sel            <= f_aux;
            compare_mode_field <= f_sel2;
            product_shift_code <= f_sel2;
            page_pointer_field <= f_page;
            mult_imm           <= f_mimm;
        end
    end

    // second word is the immediate or the program-memory operand address
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            long_operand <= 16'h0000;
        end
        else if (take_second)
        begin
            long_operand <= instr_word;
        end
    end
endmodule

/* File: dad_decoder_props.sv */
`timescale 1ns/1ps
module dad_decoder_props (
    input wire logic             clk,
    input wire logic             srst,
    input wire logic             instr_valid,
    input wire logic [15:0]      instr_word,
    input wire dad_pkg::dad_op_t op,
    input wire logic             decode_done,
    input wire logic             two_word,
    input wire logic             second_word_needed,
    input wire logic             not_in_group,
    input wire logic             addr_mode,
    input wire logic [6:0]       direct_addr,
    input wire logic [7:0]       short_imm,
    input wire logic [15:0]      long_operand,
    input wire logic [3:0]       left_shift,
    input wire logic [2:0]       aux_sel,
    input wire logic [1:0]       compare_mode_field,
    input wire logic [1:0]       product_shift_code,
    input wire logic [8:0]       page_pointer_field,
    input wire logic [12:0]      mult_imm
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // a word taken while idle is always a first word
    wire first_take = instr_valid && !second_word_needed;

    done_or_wait_a: assert property (
        first_take |=> decode_done != second_word_needed)
        else $error("first word gave neither a result nor a wait");
    operand_take_a: assert property (
        instr_valid && second_word_needed |=> decode_done && !second_word_needed
        && long_operand == $past(instr_word))
        else $error("second word not taken as operand");
    done_cause_a: assert property (
        decode_done |-> $past(instr_valid))
        else $error("result pulse without a word");
    clear_acc_a: assert property (
        first_take && instr_word == 16'hCA00 |=> op == dad_pkg::op_clear_accumulator)
        else $error("clear accumulator word misdecoded");
    fields_low_a: assert property (
        first_take |=> {addr_mode, direct_addr} == $past(instr_word[7:0])
        && short_imm == $past(instr_word[7:0]) && aux_sel == $past(instr_word[10:8]))
        else $error("address or register field wrong");
    fields_sel_a: assert property (
        first_take |=> compare_mode_field == $past(instr_word[1:0])
        && product_shift_code == $past(instr_word[1:0])
        && page_pointer_field == $past(instr_word[8:0])
        && mult_imm == $past(instr_word[12:0]))
        else $error("mode or immediate field wrong");
    foreign_word_a: assert property (
        first_take && instr_word == 16'h0000 |=> not_in_group && decode_done
        && op == dad_pkg::op_none)
        else $error("foreign word not flagged");
    xor_long_a: assert property (
        first_take && instr_word[15:12] == 4'hD && instr_word[7:0] == 8'h06
        |=> second_word_needed && two_word && !decode_done
        && left_shift == $past(instr_word[11:8]))
        else $error("long xor first word mishandled");
    mult_imm_a: assert property (
        first_take && instr_word[15:13] == 3'h5 |=> op == dad_pkg::op_multiply_immediate)
        else $error("multiply immediate misdecoded");

    cover property (instr_valid && second_word_needed);
    cover property (decode_done && not_in_group);
    cover property (first_take ##1 first_take ##1 first_take);
endmodule

/* File: dad_fetch_model.sv */
`timescale 1ns/1ps
// fetch stage stand-in; each idle step inverts the word on the bus, so it shows the
// inverse of the last word after an odd count of idle steps and the word itself after an even one
module dad_fetch_model (
    output logic        instr_valid,
    output logic [15:0] instr_word
);
    initial
    begin
        instr_valid = 1'b0;
        instr_word  = 16'h0000;
    end

    task automatic put(input logic v, input logic [15:0] w);
        instr_valid = v;
        instr_word  = v ? w : ~instr_word;
    endtask
endmodule

/* File: dad_decoder_tb.sv */
`timescale 1ns/1ps
module dad_decoder_tb;
    logic              clk;
    logic              srst;
    wire logic         instr_valid;
    wire logic [15:0]  instr_word;
    dad_pkg::dad_op_t  op;
    logic              decode_done;
    logic              two_word;
    logic              second_word_needed;
    logic              not_in_group;
    logic              addr_mode;
    logic [6:0]        direct_addr;
    logic [7:0]        short_imm;
    logic [15:0]       long_operand;
    logic [3:0]        left_shift;
    logic [2:0]        aux_sel;
    logic [1:0]        compare_mode_field;
    logic [1:0]        product_shift_code;
    logic [8:0]        page_pointer_field;
    logic [12:0]       mult_imm;
    int                err_total;
    int                check_count;
    int                cyc;

    always #20 clk = ~clk;

    dad_fetch_model i_dad_fetch_model (.instr_valid(instr_valid), .instr_word(instr_word));
    dad_decoder i_dad_decoder (.clk(clk), .srst(srst), .instr_valid(instr_valid),
        .instr_word(instr_word), .op(op), .decode_done(decode_done), .two_word(two_word),
        .second_word_needed(second_word_needed), .not_in_group(not_in_group),
        .addr_mode(addr_mode), .direct_addr(direct_addr), .short_imm(short_imm),
        .long_operand(long_operand), .left_shift(left_shift), .aux_sel(aux_sel),
        .compare_mode_field(compare_mode_field), .product_shift_code(product_shift_code),
        .page_pointer_field(page_pointer_field), .mult_imm(mult_imm));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step(input logic v, input logic [15:0] w);
        @(negedge clk);
        i_dad_fetch_model.put(v, w);
    endtask

    // words back to back; each result is judged while the next word is offered
    task automatic test_one_word;
        logic [15:0] w [34] = '{16'h46A5, 16'h4C12, 16'hCA00, 16'h4133, 16'h4081, 16'h7B7F,
            16'h7EFF, 16'hCE53, 16'h3781, 16'h7580, 16'hC5AA, 16'h5544, 16'h558E, 16'h5201,
            16'hC9FF, 16'hCE15, 16'hCE14, 16'hCE16, 16'h5302, 16'h7D03, 16'h7C04, 16'h3C05,
            16'h3D06, 16'h5B07, 16'h3F08, 16'h3E09, 16'h380A, 16'h3B0B, 16'hCF0C, 16'h3A0D,
            16'hBFFF, 16'h390E, 16'h5A0F, 16'hCE0A};
        dad_pkg::dad_op_t e [34] = '{dad_pkg::op_sub_shift_by_multiplicand,
            dad_pkg::op_xor_memory, dad_pkg::op_clear_accumulator,
            dad_pkg::op_clear_load_low_unsigned, dad_pkg::op_clear_load_high_half,
            dad_pkg::op_clear_load_high_round, dad_pkg::op_aux_add_short_imm,
            dad_pkg::op_aux_compare, dad_pkg::op_aux_load, dad_pkg::op_aux_store,
            dad_pkg::op_aux_load_short_imm, dad_pkg::op_aux_modify,
            dad_pkg::op_aux_pointer_load, dad_pkg::op_page_pointer_load,
            dad_pkg::op_page_pointer_load_imm, dad_pkg::op_add_product,
            dad_pkg::op_accumulator_from_product, dad_pkg::op_subtract_product,
            dad_pkg::op_product_high_load, dad_pkg::op_product_high_store,
            dad_pkg::op_product_low_store, dad_pkg::op_multiplicand_load,
            dad_pkg::op_multiplicand_load_accumulate, dad_pkg::op_multiplicand_load_subtract,
            dad_pkg::op_multiplicand_load_acc_move, dad_pkg::op_multiplicand_load_store_product,
            dad_pkg::op_multiply, dad_pkg::op_multiply_subtract_previous,
            dad_pkg::op_multiply_unsigned, dad_pkg::op_multiply_accumulate_previous,
            dad_pkg::op_multiply_immediate, dad_pkg::op_square_accumulate,
            dad_pkg::op_square_subtract, dad_pkg::op_product_shift_mode_set};
        for (int i = 0; i <= 34; i++)
        begin
            step(i < 34, w[i % 34]);
            if (i > 0)
            begin
                chk("op", 16'(e[i - 1]), 16'(op));
                chk("done", 16'h0001, 16'(decode_done));
                chk("group", 16'h0000, 16'(not_in_group));
                chk("two", 16'h0000, 16'(two_word));
                chk("mode", 16'(w[i - 1][7]), 16'(addr_mode));
                chk("direct", 16'(w[i - 1][6:0]), 16'(direct_addr));
                chk("short", 16'(w[i - 1][7:0]), 16'(short_imm));
                chk("aux", 16'(w[i - 1][10:8]), 16'(aux_sel));
                chk("cmpmode", 16'(w[i - 1][1:0]), 16'(compare_mode_field));
                chk("pshift", 16'(w[i - 1][1:0]), 16'(product_shift_code));
                chk("page", 16'(w[i - 1][8:0]), 16'(page_pointer_field));
                chk("kimm", 16'(w[i - 1][12:0]), 16'(mult_imm));
            end
        end
        $display("test_one_word finished");
    endtask

    // near misses of handled encodings must fall outside the group
    task automatic test_foreign;
        logic [15:0] w [4] = '{16'h0000, 16'hCA01, 16'hD302, 16'h7F00};
        foreach (w[i])
        begin
            step(1'b1, w[i]);
            step(1'b0, 16'h0000);
            chk("group", 16'h0001, 16'(not_in_group));
            chk("op", 16'(dad_pkg::op_none), 16'(op));
            chk("done", 16'h0001, 16'(decode_done));
            step(1'b0, 16'h0000);
            chk("done", 16'h0000, 16'(decode_done));
        end
        $display("test_foreign finished");
    endtask

    // operands, two of which look like opcodes, with and without a gap before them
    task automatic test_two_word;
        logic [15:0] f [4] = '{16'hD306, 16'hD500, 16'h5D81, 16'h5C7F};
        logic [15:0] s [4] = '{16'hCA00, 16'hD306, 16'hFFFF, 16'h0001};
        dad_pkg::dad_op_t e [4] = '{dad_pkg::op_xor_long_immediate,
            dad_pkg::op_aux_load_long_imm, dad_pkg::op_mult_accumulate,
            dad_pkg::op_mult_accumulate_move};
        foreach (f[i])
        begin
            step(1'b1, f[i]);
            if (i % 2 == 1)
            begin
                step(1'b0, 16'h0000);
                step(1'b0, 16'h0000);
            end
            step(1'b1, s[i]);
            chk("wait", 16'h0001, 16'(second_word_needed));
            chk("done", 16'h0000, 16'(decode_done));
            chk("two", 16'h0001, 16'(two_word));
            chk("shift", 16'(f[i][11:8]), 16'(left_shift));
            step(1'b0, 16'h0000);
            chk("op", 16'(e[i]), 16'(op));
            chk("group", 16'h0000, 16'(not_in_group));
            chk("operand", s[i], long_operand);
            chk("done", 16'h0001, 16'(decode_done));
            chk("wait", 16'h0000, 16'(second_word_needed));
        end
        $display("test_two_word finished");
    endtask

    // reset while waiting for an operand drops the wait
    task automatic test_reset_wait;
        step(1'b1, 16'h5D81);
        step(1'b0, 16'h0000);
        srst = 1'b1;
        step(1'b0, 16'h0000);
        chk("wait", 16'h0000, 16'(second_word_needed));
        chk("op", 16'(dad_pkg::op_none), 16'(op));
        chk("done", 16'h0000, 16'(decode_done));
        srst = 1'b0;
        step(1'b1, 16'hCE16);
        step(1'b0, 16'h0000);
        chk("op", 16'(dad_pkg::op_subtract_product), 16'(op));
        $display("test_reset_wait finished");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // whole run needs about 70 cycles; the ceiling leaves ample margin
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        err_total = 0;
        check_count = 0;
        cyc = 0;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        test_one_word();
        test_foreign();
        test_two_word();
        test_reset_wait();
        results();
    end
endmodule

bind dad_decoder dad_decoder_props i_dad_decoder_props (.clk(clk), .srst(srst),
    .instr_valid(instr_valid), .instr_word(instr_word), .op(op), .decode_done(decode_done),
    .two_word(two_word), .second_word_needed(second_word_needed),
    .not_in_group(not_in_group), .addr_mode(addr_mode), .direct_addr(direct_addr),
    .short_imm(short_imm), .long_operand(long_operand), .left_shift(left_shift),
    .aux_sel(aux_sel), .compare_mode_field(compare_mode_field),
    .product_shift_code(product_shift_code), .page_pointer_field(page_pointer_field),
    .mult_imm(mult_imm));
